// ### rtl/agd_regs.v
// ADC level control fields and GPIO direction register, APB slave
// Assumes APB master on clock; rst_n is the power-up reset only
//
// Functional notes
// R1 - ADC mute 0 passes samples; 1 (default) forces midscale zero
// R2 - Source, boost and gain act only while pairing select is 0
// R3 - Source select 0 routes receive line input, 1 routes microphone
// R4 - Software sets mic pin assignment before choosing microphone source
// R5 - Boost adds 0 or 20 dB; total gain is boost plus level
// R6 - Gain level spans 0.0 dB at code 0 to 22.5 dB at 15
// R7 - Direction bit 0 makes pin output, 1 makes pin input
// R8 - After power-up all pins are inputs with weak pull-ups
// R9 - Direction register loads 0x00FF only at power-up reset
// R10 - Pin 1 always input; its bit reads 1, writes ignored
// R11 - Direction bit ignored when pin serves an alternate function
// R12 - Direction bits 15 to 8 read zero; writes discarded
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "agd_regs.vh"

module agd_regs (
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [15:0] adc_sample_in,
	input wire adc_sample_valid,
	input wire [7:0] alt_func_en,
	output reg [15:0] adc_sample_out,
	output reg adc_sample_out_valid,
	output reg adc_mic_route,
	output reg [7:0] adc_gain_db,
	output reg adc_gain_half_db,
	output reg [7:0] gpio_dir_in,
	output reg [7:0] gpio_pullup_req
);

// ----------------------------------------
// Address decode
// ----------------------------------------
function is_mapped;
	input [7:0] a;
	begin
		is_mapped = (a == `AGD_LEVEL_OFF) || (a == `AGD_DIR_OFF) ||
			(a == `AGD_CTRL_OFF) || (a == `AGD_MICPIN_OFF) ||
			(a == `AGD_STAT_OFF);
	end
endfunction

reg [15:0] level_reg;
reg [15:0] level_next;
reg [7:0] dir_reg;
reg [7:0] dir_next;
reg [15:0] ctrl_reg;
reg [15:0] ctrl_next;
reg [15:0] micpin_reg;
reg [15:0] micpin_next;
reg [31:0] rdata_next;
reg [8:0] gain_half_total;
wire setup_ph;
wire access_ph;
wire wr_hit;
wire wr_level;
wire wr_dir;
wire wr_ctrl;
wire wr_micpin;
wire [7:0] dir_eff;
wire adc_active;
wire [3:0] gain_code;
wire [5:0] gain_half_level;

// ----------------------------------------
// Decode functions
// ----------------------------------------
// Write strobe for one register offset
function wr_sel;
	input [7:0] a;
	input [7:0] off;
	input hit;
	begin
		wr_sel = hit && (a == off);
	end
endfunction

// Gain level code to half-dB count, 1.5 dB per step
function [5:0] gain_half_of;
	input [3:0] code;
	begin
		case (code)
			4'h0: gain_half_of = 6'h00;
			4'h1: gain_half_of = 6'h03;
			4'h2: gain_half_of = 6'h06;
			4'h3: gain_half_of = 6'h09;
			4'h4: gain_half_of = 6'h0C;
			4'h5: gain_half_of = 6'h0F;
			4'h6: gain_half_of = 6'h12;
			4'h7: gain_half_of = 6'h15;
			4'h8: gain_half_of = 6'h18;
			4'h9: gain_half_of = 6'h1B;
			4'hA: gain_half_of = 6'h1E;
			4'hB: gain_half_of = 6'h21;
			4'hC: gain_half_of = 6'h24;
			4'hD: gain_half_of = 6'h27;
			4'hE: gain_half_of = 6'h2A;
			4'hF: gain_half_of = 6'h2D;
			default: gain_half_of = 6'h00;
		endcase
	end
endfunction

// ----------------------------------------
// Bus phases
// ----------------------------------------
// Zero-wait: answer in the access cycle after setup
assign setup_ph = psel && !penable;
// Writes land at the edge where the access phase meets ready
assign access_ph = psel && penable && pready;
assign wr_hit = access_ph && pwrite;
assign wr_level = wr_sel(paddr, `AGD_LEVEL_OFF, wr_hit);
assign wr_dir = wr_sel(paddr, `AGD_DIR_OFF, wr_hit);
assign wr_ctrl = wr_sel(paddr, `AGD_CTRL_OFF, wr_hit);
assign wr_micpin = wr_sel(paddr, `AGD_MICPIN_OFF, wr_hit);

// ----------------------------------------
// Register writes
// ----------------------------------------
always @* begin
	level_next = level_reg;
	if (wr_level) begin
		level_next = (level_reg & ~`AGD_LEVEL_ADC_MASK) |
			(pwdata[15:0] & `AGD_LEVEL_ADC_MASK);
	end
end

always @* begin
	dir_next = dir_reg;
	if (wr_dir) begin
		dir_next = pwdata[7:0]; // R7 R12
		dir_next[1] = 1'b1; // R10
	end
end

always @* begin
	ctrl_next = ctrl_reg;
	if (wr_ctrl) begin
		ctrl_next = {15'h0000, pwdata[`AGD_PAIR_SEL_BIT]};
	end
end

always @* begin
	micpin_next = micpin_reg;
	if (wr_micpin) begin
		micpin_next = {15'h0000, pwdata[`AGD_MIC_PIN_BIT]};
	end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
	rdata_next = 32'h00000000;
	case (paddr)
		`AGD_LEVEL_OFF: rdata_next = {16'h0000, level_reg};
		`AGD_DIR_OFF: rdata_next = {24'h000000, dir_reg}; // R12 R10
		`AGD_CTRL_OFF: rdata_next = {16'h0000, ctrl_reg};
		`AGD_MICPIN_OFF: rdata_next = {16'h0000, micpin_reg};
		`AGD_STAT_OFF: rdata_next = {24'h000000, dir_eff};
		default: rdata_next = 32'h00000000;
	endcase
end

// ----------------------------------------
// Register flops, power-up reset only
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		level_reg <= `AGD_LEVEL_RST; // R1
	end else begin
		level_reg <= level_next;
	end
end

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		dir_reg <= `AGD_DIR_RST; // R9 R8
	end else begin
		dir_reg <= dir_next;
	end
end

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		ctrl_reg <= `AGD_CTRL_RST;
	end else begin
		ctrl_reg <= ctrl_next;
	end
end

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		micpin_reg <= `AGD_MICPIN_RST;
	end else begin
		micpin_reg <= micpin_next;
	end
end

// ----------------------------------------
// Bus response
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		pready <= setup_ph;
		pslverr <= setup_ph && !is_mapped(paddr);
		if (setup_ph && !pwrite) begin
			prdata <= rdata_next;
		end
	end
end

// ----------------------------------------
// GPIO direction outputs
// ----------------------------------------
// Alternate-function pins ignore their bit and stay inputs
genvar gi;
generate
	for (gi = 0; gi < `AGD_NPINS; gi = gi + 1) begin : g_pin
		assign dir_eff[gi] = dir_reg[gi] | alt_func_en[gi]; // R11 R7
	end
endgenerate

// ----------------------------------------
// ADC path
// ----------------------------------------
assign adc_active = (ctrl_reg[`AGD_PAIR_SEL_BIT] == 1'b0); // R2
assign gain_code = level_reg[`AGD_ADC_GAIN_MSB:`AGD_ADC_GAIN_LSB];
assign gain_half_level = gain_half_of(gain_code); // R6

// Total held as half-dB count
always @* begin
	gain_half_total = 9'h000;
	if (adc_active) begin
		gain_half_total = {3'h0, gain_half_level}; // R6
		if (level_reg[`AGD_ADC_BOOST_BIT]) begin
			gain_half_total = gain_half_total +
				{`AGD_BOOST_DB, 1'b0}; // R5
		end
	end
end

// ----------------------------------------
// ADC outputs
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		adc_sample_out <= `AGD_MIDSCALE;
		adc_sample_out_valid <= 1'b0;
	end else begin
		adc_sample_out_valid <= adc_sample_valid;
		if (level_reg[`AGD_ADC_MUTE_BIT]) begin
			adc_sample_out <= `AGD_MIDSCALE; // R1
		end else begin
			adc_sample_out <= adc_sample_in; // R1
		end
	end
end

// Mic route also needs pin assigned away from GPIO
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		adc_mic_route <= 1'b0;
	end else begin
		adc_mic_route <= adc_active && level_reg[`AGD_ADC_SRC_BIT] &&
			micpin_reg[`AGD_MIC_PIN_BIT]; // R3 R4
	end
end

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		adc_gain_db <= 8'h00;
		adc_gain_half_db <= 1'b0;
	end else begin
		adc_gain_db <= gain_half_total[8:1]; // R5
		adc_gain_half_db <= gain_half_total[0]; // R6
	end
end

// ----------------------------------------
// GPIO outputs
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		gpio_dir_in <= `AGD_DIR_RST; // R8
		gpio_pullup_req <= `AGD_DIR_RST; // R8
	end else begin
		gpio_dir_in <= dir_eff; // R7
		gpio_pullup_req <= dir_eff; // R8
	end
end

endmodule

// ### rtl/agd_regs.vh
// Register map, field positions, reset values for ADC level and GPIO direction
// Assumes inclusion by the single design file of this block
`ifndef AGD_REGS_VH
`define AGD_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AGD_LEVEL_OFF 8'h46
`define AGD_DIR_OFF 8'h4C
`define AGD_CTRL_OFF 8'h5C
`define AGD_MICPIN_OFF 8'h5E
`define AGD_STAT_OFF 8'h60

// ----------------------------------------
// Level control fields
// ----------------------------------------
`define AGD_ADC_MUTE_BIT 7
`define AGD_ADC_SRC_BIT 5
`define AGD_ADC_BOOST_BIT 4
`define AGD_ADC_GAIN_MSB 3
`define AGD_ADC_GAIN_LSB 0
`define AGD_LEVEL_ADC_MASK 16'h00BF

// ----------------------------------------
// Control and pin-assign fields
// ----------------------------------------
`define AGD_PAIR_SEL_BIT 0
`define AGD_MIC_PIN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AGD_LEVEL_RST 16'h8080
`define AGD_DIR_RST 8'hFF
`define AGD_CTRL_RST 16'h0000
`define AGD_MICPIN_RST 16'h0000

// ----------------------------------------
// Gain and samples
// ----------------------------------------
`define AGD_BOOST_DB 8'h14
`define AGD_GAIN_STEP_X10 8'h0F
`define AGD_MIDSCALE 16'h0000
`define AGD_NPINS 8

`endif

// ### tb/agd_chk.sv
// Port assertions for the level and direction register block
// Bound into agd_regs; sees only its ports
`timescale 1ns/10ps
module agd_chk (
	input wire clock,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [15:0] adc_sample_in,
	input wire [15:0] adc_sample_out,
	input wire [7:0] adc_gain_db,
	input wire [7:0] alt_func_en,
	input wire [7:0] gpio_dir_in,
	input wire [7:0] gpio_pullup_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_rd;
		psel && !penable && !pwrite && paddr == 8'h4C
		|=> prdata[31:8] == 24'h0 && prdata[1];
	endproperty
	a_rd: assert property (p_rd) else $error("dir read");
	property p_pin1; gpio_dir_in[1]; endproperty
	a_pin1: assert property (p_pin1) else $error("pin1");
	property p_alt;
		|alt_func_en |=> (gpio_dir_in & $past(alt_func_en)) ==
		$past(alt_func_en);
	endproperty
	a_alt: assert property (p_alt) else $error("alt pin");
	property p_pu; gpio_pullup_req == gpio_dir_in; endproperty
	a_pu: assert property (p_pu) else $error("pull-up");
	property p_smp;
		adc_sample_out != 16'h0 |-> adc_sample_out == $past(adc_sample_in);
	endproperty
	a_smp: assert property (p_smp) else $error("sample");
	property p_gain; adc_gain_db <= 8'h2A; endproperty
	a_gain: assert property (p_gain) else $error("gain");
	c_err: cover property (pslverr);
	c_smp: cover property (adc_sample_out != 16'h0);
	c_alt: cover property (|alt_func_en);
endmodule
bind agd_regs agd_chk chk_u (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .adc_sample_in(adc_sample_in),
	.adc_sample_out(adc_sample_out), .adc_gain_db(adc_gain_db),
	.alt_func_en(alt_func_en), .gpio_dir_in(gpio_dir_in),
	.gpio_pullup_req(gpio_pullup_req));

// ### tb/agd_host.sv
// Host model: APB master reaching the codec registers
// Called through task xfer just after a rising edge
`timescale 1ns/10ps
module agd_host (
	input wire clock,
	output reg psel,
	output reg penable,
	output reg pwrite,
	output reg [7:0] paddr,
	output reg [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	initial psel = 1'b0;
	initial penable = 1'b0;
	initial pwrite = 1'b0;
	initial paddr = 8'h00;
	initial pwdata = 32'h0;
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule

// ### tb/agd_regs_test.sv
// Self-checking bench for agd_regs with host model
// Fixed random seed; one 100 MHz clock
`timescale 1ns/10ps
module agd_regs_test;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic adc_sample_valid, adc_sample_out_valid, adc_mic_route;
	logic adc_gain_half_db;
	logic [7:0] paddr, alt_func_en, adc_gain_db, gpio_dir_in;
	logic [7:0] gpio_pullup_req;
	logic [31:0] pwdata, prdata, rd, d;
	logic [15:0] adc_sample_in, adc_sample_out;
	int fail_count = 0, n_checks = 0, cyc = 0;
	agd_regs dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_sample_in(adc_sample_in),
		.adc_sample_valid(adc_sample_valid), .alt_func_en(alt_func_en),
		.adc_sample_out(adc_sample_out),
		.adc_sample_out_valid(adc_sample_out_valid),
		.adc_mic_route(adc_mic_route), .adc_gain_db(adc_gain_db),
		.adc_gain_half_db(adc_gain_half_db), .gpio_dir_in(gpio_dir_in),
		.gpio_pullup_req(gpio_pullup_req));
	agd_host host_u (.clock(clock), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task stop_test;
		$display("checks %0d fails %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function logic [7:0] gexp(input logic b, input logic [3:0] c);
		return (b ? 8'h14 : 8'h00) + ({4'h0, c} * 8'h0F) / 8'h0A;
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] v);
		host_u.xfer(1'b1, a, v, rd, e);
		repeat (2) @(posedge clock);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x);
		host_u.xfer(1'b0, a, 32'h0, rd, e);
		chk(rd, x);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		rst_n = 1'b0;
		adc_sample_in = 16'h0;
		adc_sample_valid = 1'b0;
		alt_func_en = 8'h00;
		void'($urandom(25));
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rdc(8'h4C, 32'hFF);
		rdc(8'h46, 32'h8080);
		chk(gpio_dir_in, 32'hFF);
		chk(gpio_pullup_req, 32'hFF);
		adc_sample_in <= $urandom | 32'h1;
		adc_sample_valid <= 1'b1;
		repeat (3) @(posedge clock);
		chk(adc_sample_out, 32'h0);
		wr(8'h46, 32'h0);
		chk(adc_sample_out, adc_sample_in);
		chk(adc_sample_out_valid, 32'h1);
		rdc(8'h46, 32'h8000);
		for (int i = 0; i < 4; i++) begin
			d = i ? $urandom : 32'hFFFF0000;
			alt_func_en <= i[0] ? $urandom : 8'h00;
			wr(8'h4C, d);
			chk(gpio_dir_in, d[7:0] | 8'h02 | alt_func_en);
			rdc(8'h4C, {24'h0, d[7:0] | 8'h02});
			rdc(8'h60, {24'h0, d[7:0] | 8'h02 | alt_func_en});
		end
		host_u.xfer(1'b1, 8'h10, 32'hFFFF, rd, e);
		chk(e, 32'h1);
		rdc(8'h10, 32'h0);
		chk(e, 32'h1);
		wr(8'h5E, 32'h1);
		for (int i = 0; i < 6; i++) begin
			d = i ? $urandom : 32'h1F;
			wr(8'h46, {26'h0, 1'b1, d[4:0]});
			chk(adc_gain_db, gexp(d[4], d[3:0]));
			chk(adc_gain_half_db, d[0]);
			chk(adc_mic_route, 32'h1);
		end
		wr(8'h5C, 32'h1);
		chk(adc_gain_db, 32'h0);
		chk(adc_mic_route, 32'h0);
		wr(8'h5C, 32'h0);
		wr(8'h46, 32'hF);
		chk(adc_mic_route, 32'h0);
		chk(adc_gain_db, gexp(1'b0, 4'hF));
		chk(adc_gain_half_db, 32'h1);
		wr(8'h5E, 32'h0);
		wr(8'h46, 32'h20);
		chk(adc_mic_route, 32'h0);
		wr(8'h46, 32'h80);
		chk(adc_sample_out, 32'h0);
		stop_test;
	end
endmodule
